// ---- core/tmr_consts.svh ----
// register offsets, field positions, reset values and codes of the 16-bit timer
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TMR_OFF_CTRL      12'h000
`define TMR_OFF_EVCTRL    12'h004
`define TMR_OFF_RELOAD    12'h008
`define TMR_OFF_COUNT     12'h00c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define TMR_CTRL_EN       0
`define TMR_CTRL_RST      1
`define TMR_CTRL_MODE_LO  2
`define TMR_CTRL_MODE_HI  3
`define TMR_CTRL_DIR      5
`define TMR_CTRL_RWRAP    7

// ----------------------------------------------------------------
// clock and event control fields
// ----------------------------------------------------------------
`define TMR_EVC_TCLK_LO   0
`define TMR_EVC_TCLK_HI   3
`define TMR_EVC_EDGE_LO   5
`define TMR_EVC_EDGE_HI   6
`define TMR_EVC_EVT       7

// ----------------------------------------------------------------
// codes and values
// ----------------------------------------------------------------
`define TMR_MODE_TIMER    2'h0
`define TMR_MODE_EVENT    2'h1
`define TMR_MODE_ONESHOT  2'h2
`define TMR_MODE_RSVD     2'h3
`define TMR_EDGE_RISE     2'h0
`define TMR_EDGE_FALL     2'h1
`define TMR_EDGE_BOTH     2'h2
`define TMR_EDGE_NONE     2'h3
`define TMR_CNT_MAX       16'hffff
`define TMR_CNT_MIN       16'h0000
`define TMR_CNT_ONE       16'h0001
`define TMR_RELOAD_RST    16'h0000
`define TMR_TCLK_RST      4'h0
`define TMR_PRE_ONE       16'h0001
`define TMR_ZERO16        16'h0000

`endif

// ---- core/tmr_pkg.sv ----
// types shared by the 16-bit timer files
`include "tmr_consts.svh"

package tmr_pkg;

  // ----------------------------------------------------------------
  // modes, edge qualifiers and one-shot states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TIMER   = `TMR_MODE_TIMER,
    MODE_EVENT   = `TMR_MODE_EVENT,
    MODE_ONESHOT = `TMR_MODE_ONESHOT,
    MODE_RSVD    = `TMR_MODE_RSVD
  } tmr_mode_t;

  typedef enum logic [1:0] {
    EDGE_RISE = `TMR_EDGE_RISE,
    EDGE_FALL = `TMR_EDGE_FALL,
    EDGE_BOTH = `TMR_EDGE_BOTH,
    EDGE_NONE = `TMR_EDGE_NONE
  } tmr_edge_t;

  typedef enum logic [1:0] {
    OS_IDLE = 2'b01,
    OS_RUN  = 2'b10
  } tmr_os_state_t;

endpackage : tmr_pkg

// ---- core/tmr_tick_gen.sv ----
// timer clock prescaler and overflow-edge qualifier for the 16-bit timer
`timescale 1ns/1ns
`include "tmr_consts.svh"

module tmr_tick_gen
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  // configuration
  input  wire logic [3:0] tclk_sel_in,
  input  wire logic [1:0] edge_sel_in,
  // overflow from the preceding timer, same clock domain
  input  wire logic       ovf_in,
  // tick strobes
  output logic            clk_tick_out,
  output logic            evt_tick_out
);

  logic [14:0] prescale_reg;
  logic [14:0] prescale_next;
  logic [14:0] pre_mask;
  logic        pre_hit;
  logic        ovf_prev_reg;
  logic        ovf_rise;
  logic        ovf_fall;
  logic        evt_qual;
  logic        clk_tick_reg;
  logic        evt_tick_reg;

  // ----------------------------------------------------------------
  // prescaler: tick every 2^tclk_sel cycles
  // ----------------------------------------------------------------
  assign pre_mask      = 15'((`TMR_PRE_ONE << tclk_sel_in) - `TMR_PRE_ONE);
  assign pre_hit       = (prescale_reg & pre_mask) == pre_mask;
  assign prescale_next = 15'(prescale_reg + 15'h0001);

  // ----------------------------------------------------------------
  // edge qualifier on the preceding timer's overflow
  // ----------------------------------------------------------------
  assign ovf_rise = ovf_in & ~ovf_prev_reg;
  assign ovf_fall = ~ovf_in & ovf_prev_reg;
  assign evt_qual = (edge_sel_in == tmr_pkg::EDGE_RISE) ? ovf_rise :
                    (edge_sel_in == tmr_pkg::EDGE_FALL) ? ovf_fall :
                    (edge_sel_in == tmr_pkg::EDGE_BOTH) ? (ovf_rise | ovf_fall) :
                    1'b0;

  // registered strobes, one cycle of latency each
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      prescale_reg <= 15'h0000;
      ovf_prev_reg <= 1'b0;
      clk_tick_reg <= 1'b0;
      evt_tick_reg <= 1'b0;
    end
    else
    begin
      prescale_reg <= prescale_next;
      ovf_prev_reg <= ovf_in;
      clk_tick_reg <= pre_hit;
      evt_tick_reg <= evt_qual;
    end
  end

  assign clk_tick_out = clk_tick_reg;
  assign evt_tick_out = evt_tick_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_edge_rise;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (edge_sel_in == tmr_pkg::EDGE_RISE) && ovf_in && !ovf_prev_reg |=> evt_tick_out;
  endproperty
  a_edge_rise: assert property (p_edge_rise) else $error("rising edge not counted");

  property p_edge_fall_only;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (edge_sel_in == tmr_pkg::EDGE_FALL) && ovf_in |=> !evt_tick_out;
  endproperty
  a_edge_fall_only: assert property (p_edge_fall_only) else $error("tick on wrong edge");

endmodule : tmr_tick_gen

// ---- core/tmr_timer16.sv ----
// 16-bit timer with event counting and one-shot modes behind an APB slave
`timescale 1ns/1ns
`include "tmr_consts.svh"

module tmr_timer16
#(
  parameter int ADDR_W = 12
)
(
  // clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              rst_b_in,
  // apb slave
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // timer chain
  input  wire logic              ovf_in,
  output logic                   ovf_out,
  // interrupt request pulse
  output logic                   irq_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  tmr_pkg::tmr_mode_t     mode_reg;
  tmr_pkg::tmr_os_state_t os_reg;
  tmr_pkg::tmr_os_state_t os_next;
  logic        en_reg;
  logic        en_next;
  logic        rst_pend_reg;
  logic        rst_pend_next;
  logic        dir_up_reg;
  logic        rwrap_reg;
  logic        evt_sel_reg;
  logic [1:0]  edge_reg;
  logic [3:0]  tclk_reg;
  logic [15:0] reload_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        pend_reg;
  logic        pend_next;
  logic        wrap_reg;
  logic        wrap_next;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        clk_tick;
  logic        evt_tick;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        wr_en;
  logic        wr_ctrl;
  logic        wr_evc;
  logic        wr_reload;
  logic        rd_setup;
  logic        hit_ctrl;
  logic        hit_evc;
  logic        hit_reload;
  logic        hit_count;
  logic        unmapped;
  logic [31:0] ctrl_word;
  logic [31:0] evc_word;
  logic [31:0] rd_word;

  assign hit_ctrl   = paddr_in == ADDR_W'(`TMR_OFF_CTRL);
  assign hit_evc    = paddr_in == ADDR_W'(`TMR_OFF_EVCTRL);
  assign hit_reload = paddr_in == ADDR_W'(`TMR_OFF_RELOAD);
  assign hit_count  = paddr_in == ADDR_W'(`TMR_OFF_COUNT);
  assign unmapped   = !(hit_ctrl | hit_evc | hit_reload | hit_count);
  assign wr_en      = psel_in & penable_in & pwrite_in;
  assign wr_ctrl    = wr_en & hit_ctrl;
  assign wr_evc     = wr_en & hit_evc;
  assign wr_reload  = wr_en & hit_reload;
  assign rd_setup   = psel_in & !penable_in;

  // read words, reserved bits read as zero
  always_comb
  begin
    ctrl_word                                     = 32'h0000_0000;
    ctrl_word[`TMR_CTRL_EN]                       = en_reg;
    ctrl_word[`TMR_CTRL_RST]                      = rst_pend_reg;
    ctrl_word[`TMR_CTRL_MODE_HI:`TMR_CTRL_MODE_LO] = mode_reg;
    ctrl_word[`TMR_CTRL_DIR]                      = dir_up_reg;
    ctrl_word[`TMR_CTRL_RWRAP]                    = rwrap_reg;
    evc_word                                      = 32'h0000_0000;
    evc_word[`TMR_EVC_TCLK_HI:`TMR_EVC_TCLK_LO]   = tclk_reg;
    evc_word[`TMR_EVC_EDGE_HI:`TMR_EVC_EDGE_LO]   = edge_reg;
    evc_word[`TMR_EVC_EVT]                        = evt_sel_reg;
  end

  assign rd_word = hit_ctrl   ? ctrl_word :
                   hit_evc    ? evc_word :
                   hit_reload ? {`TMR_ZERO16, reload_reg} :
                   hit_count  ? {`TMR_ZERO16, cnt_reg} :
                   32'h0000_0000;

  // read data captured in setup so it comes from a flop; zero wait states
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata_reg  <= pwrite_in ? 32'h0000_0000 : rd_word;
      pslverr_reg <= unmapped;
    end
  end

  assign prdata_out  = prdata_reg;
  assign pready_out  = psel_in & penable_in;
  assign pslverr_out = pslverr_reg & psel_in & penable_in;

  // ----------------------------------------------------------------
  // configuration registers written only by software
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mode_reg    <= tmr_pkg::MODE_TIMER;
      dir_up_reg  <= 1'b0;
      rwrap_reg   <= 1'b0;
      evt_sel_reg <= 1'b0;
      edge_reg    <= `TMR_EDGE_RISE;
      tclk_reg    <= `TMR_TCLK_RST;
      reload_reg  <= `TMR_RELOAD_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode_reg  <= tmr_pkg::tmr_mode_t'(pwdata_in[`TMR_CTRL_MODE_HI:`TMR_CTRL_MODE_LO]);
        dir_up_reg <= pwdata_in[`TMR_CTRL_DIR];
        rwrap_reg  <= pwdata_in[`TMR_CTRL_RWRAP];
      end
      if (wr_evc)
      begin
        tclk_reg    <= pwdata_in[`TMR_EVC_TCLK_HI:`TMR_EVC_TCLK_LO];
        edge_reg    <= pwdata_in[`TMR_EVC_EDGE_HI:`TMR_EVC_EDGE_LO];
        evt_sel_reg <= pwdata_in[`TMR_EVC_EVT];
      end
      if (wr_reload)
        reload_reg <= pwdata_in[15:0];
    end
  end

  // ----------------------------------------------------------------
  // tick sources
  // ----------------------------------------------------------------
  tmr_tick_gen u_tick
  (
    .ref_clk_in   (ref_clk_in),
    .rst_b_in     (rst_b_in),
    .tclk_sel_in  (tclk_reg),
    .edge_sel_in  (edge_reg),
    .ovf_in       (ovf_in),
    .clk_tick_out (clk_tick),
    .evt_tick_out (evt_tick)
  );

  // ----------------------------------------------------------------
  // counter control
  // ----------------------------------------------------------------
  logic        is_event;
  logic        is_oneshot;
  logic        cnt_tick;
  logic        os_tick;
  logic        os_start;
  logic        running;
  logic        at_min;
  logic        at_max;
  logic [15:0] rst_load;
  logic [15:0] cnt_dec;
  logic [15:0] cnt_inc;

  assign is_event   = mode_reg == tmr_pkg::MODE_EVENT;
  assign is_oneshot = mode_reg == tmr_pkg::MODE_ONESHOT;
  assign cnt_tick   = is_event ? evt_tick : clk_tick;
  assign os_tick    = evt_sel_reg ? evt_tick : clk_tick;
  assign os_start   = en_reg & (evt_sel_reg ? evt_tick : 1'b1);
  assign running    = is_oneshot ? (os_reg == tmr_pkg::OS_RUN) :
                      (en_reg & (mode_reg != tmr_pkg::MODE_RSVD));
  assign at_min     = cnt_reg == `TMR_CNT_MIN;
  assign at_max     = cnt_reg == `TMR_CNT_MAX;
  assign rst_load   = (is_event & dir_up_reg) ? `TMR_CNT_MIN : reload_reg;
  assign cnt_dec    = cnt_reg - `TMR_CNT_ONE;
  assign cnt_inc    = cnt_reg + `TMR_CNT_ONE;

  // next state; hardware clears come first so a software set wins
  always_comb
  begin
    cnt_next      = cnt_reg;
    en_next       = en_reg;
    rst_pend_next = rst_pend_reg;
    pend_next     = pend_reg;
    os_next       = os_reg;
    wrap_next     = 1'b0;
    if (rst_pend_reg)
    begin
      // reset cycle: stop, load, clear enable, self clear; no interrupt
      cnt_next      = rst_load;
      en_next       = 1'b0;
      rst_pend_next = 1'b0;
      pend_next     = 1'b0;
      os_next       = tmr_pkg::OS_IDLE;
    end
    else
    begin
      case (mode_reg)
        tmr_pkg::MODE_TIMER,
        tmr_pkg::MODE_EVENT:
        begin
          if (en_reg && cnt_tick)
          begin
            if (is_event && dir_up_reg)
            begin
              wrap_next = at_max;
              cnt_next  = !at_max ? cnt_inc :
                          rwrap_reg ? reload_reg : `TMR_CNT_MIN;
            end
            else
            begin
              wrap_next = at_min;
              cnt_next  = !at_min ? cnt_dec :
                          (rwrap_reg || pend_reg) ? reload_reg : `TMR_CNT_MAX;
              if (at_min)
                pend_next = 1'b0;
            end
          end
        end
        tmr_pkg::MODE_ONESHOT:
        begin
          case (os_reg)
            tmr_pkg::OS_IDLE:
            begin
              if (os_start)
              begin
                cnt_next  = reload_reg;
                pend_next = 1'b0;
                os_next   = tmr_pkg::OS_RUN;
              end
            end
            tmr_pkg::OS_RUN:
            begin
              if (os_tick)
              begin
                en_next = 1'b0;
                if (at_min)
                begin
                  // stop here whatever reload_on_wrap says
                  wrap_next = 1'b1;
                  os_next   = tmr_pkg::OS_IDLE;
                  cnt_next  = pend_reg ? reload_reg : `TMR_CNT_MIN;
                  pend_next = 1'b0;
                end
                else
                  cnt_next = cnt_dec;
              end
            end
            default:
              os_next = tmr_pkg::OS_IDLE;
          endcase
        end
        default:
          cnt_next = cnt_reg;
      endcase
      // reload writes: copy now when stopped, defer when running
      if (wr_reload && !running)
        cnt_next = pwdata_in[15:0];
      else if (wr_reload)
        pend_next = 1'b1;
    end
    if (wr_ctrl)
    begin
      en_next       = pwdata_in[`TMR_CTRL_EN];
      rst_pend_next = rst_pend_next | pwdata_in[`TMR_CTRL_RST];
    end
  end

  // counter state flops
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt_reg      <= `TMR_CNT_MIN;
      en_reg       <= 1'b0;
      rst_pend_reg <= 1'b0;
      pend_reg     <= 1'b0;
      os_reg       <= tmr_pkg::OS_IDLE;
      wrap_reg     <= 1'b0;
    end
    else
    begin
      cnt_reg      <= cnt_next;
      en_reg       <= en_next;
      rst_pend_reg <= rst_pend_next;
      pend_reg     <= pend_next;
      os_reg       <= os_next;
      wrap_reg     <= wrap_next;
    end
  end

  // one pulse serves both the interrupt and the next timer in the chain
  assign irq_out = wrap_reg;
  assign ovf_out = wrap_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_rst_cycle;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    rst_pend_reg && !wr_ctrl |=> cnt_reg == $past(rst_load) && !en_reg && !rst_pend_reg;
  endproperty
  a_rst_cycle: assert property (p_rst_cycle) else $error("reset cycle wrong");

  property p_evt_down;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    is_event && en_reg && evt_tick && !dir_up_reg && !at_min && !rst_pend_reg && !wr_reload
    |=> cnt_reg == $past(cnt_dec) && !irq_out;
  endproperty
  a_evt_down: assert property (p_evt_down) else $error("event down count wrong");

  property p_evt_up;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    is_event && en_reg && evt_tick && dir_up_reg && !at_max && !rst_pend_reg
    |=> cnt_reg == $past(cnt_reg) + `TMR_CNT_ONE;
  endproperty
  a_evt_up: assert property (p_evt_up) else $error("event up count wrong");

  property p_underflow;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    is_event && en_reg && evt_tick && !dir_up_reg && at_min && !pend_reg && !rst_pend_reg
    && !wr_reload |=> irq_out && cnt_reg == ($past(rwrap_reg) ? $past(reload_reg) : `TMR_CNT_MAX);
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow wrap wrong");

  property p_overflow;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    is_event && en_reg && evt_tick && dir_up_reg && at_max && !rst_pend_reg
    |=> irq_out && ovf_out && cnt_reg == ($past(rwrap_reg) ? $past(reload_reg) : `TMR_CNT_MIN);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow wrap wrong");

  property p_evt_hold;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    is_event && !en_reg && !rst_pend_reg && !wr_reload |=> $stable(cnt_reg) && !irq_out;
  endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("counter moved while disabled");

  property p_os_start;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    is_oneshot && os_reg == tmr_pkg::OS_IDLE && en_reg && !evt_sel_reg && !rst_pend_reg
    && !wr_reload |=> os_reg == tmr_pkg::OS_RUN && cnt_reg == $past(reload_reg);
  endproperty
  a_os_start: assert property (p_os_start) else $error("one-shot start wrong");

  property p_os_en_clear;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    is_oneshot && os_reg == tmr_pkg::OS_RUN && os_tick && !wr_ctrl |=> !en_reg;
  endproperty
  a_os_en_clear: assert property (p_os_en_clear) else $error("enable not cleared");

  property p_os_stop;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    is_oneshot && os_reg == tmr_pkg::OS_RUN && os_tick && at_min && !rst_pend_reg
    |=> irq_out && os_reg == tmr_pkg::OS_IDLE ##1 !irq_out;
  endproperty
  a_os_stop: assert property (p_os_stop) else $error("one-shot stop wrong");

  property p_read_count;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    rd_setup && !pwrite_in && hit_count |=> prdata_out == {`TMR_ZERO16, $past(cnt_reg)};
  endproperty
  a_read_count: assert property (p_read_count) else $error("count read wrong");

endmodule : tmr_timer16

// ---- testbench/tmr_prev_model.sv ----
// behavioural model of the preceding timer that drives the overflow chain
`timescale 1ns/1ns

module tmr_prev_model
(
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic rst_b_in,
  // bench command: flip the overflow level at the next edge
  input  wire logic flip_in,
  // overflow level into the timer under test
  output logic      ovf_out
);
  // ----------------------------------------------------------------
  // overflow level
  // ----------------------------------------------------------------
  // a level, not a pulse, so both edge qualifiers can be exercised
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ovf_out <= 1'b0;
    else if (flip_in)
      ovf_out <= ~ovf_out;
  end
endmodule : tmr_prev_model

// ---- testbench/test_tmr_timer16.sv ----
// self-checking bench for the timer event and one-shot modes
`timescale 1ns/1ns

module test_tmr_timer16;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic        ovf;
  logic        ovf_o;
  logic        irq;
  logic        flip = 1'b0;
  logic [31:0] rv;
  logic        ev;
  int          num_errors = 0;
  int          num_checks = 0;
  int          irq_n = 0;
  int          ovf_n = 0;
  int          cyc = 0;

  tmr_prev_model prev (.ref_clk_in(clk), .rst_b_in(rst_b), .flip_in(flip), .ovf_out(ovf));

  tmr_timer16 dut (.ref_clk_in(clk), .rst_b_in(rst_b), .paddr_in(paddr), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .ovf_in(ovf), .ovf_out(ovf_o), .irq_out(irq));

  // ----------------------------------------------------------------
  // clock, pulse counters and hang guard
  // ----------------------------------------------------------------
  always #25 clk = ~clk;

  // whole run is well under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (irq === 1'b1)
      irq_n++;
    if (ovf_o === 1'b1)
      ovf_n++;
    if (cyc == 3000)
    begin
      num_errors++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task summarize();
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one apb transfer; read data and error land in rv and ev
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    paddr <= a;
    pwr <= w;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1)
      @(posedge clk);
    rv = prd;
    ev = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : xfer

  // each flip lands after two edges of qualifier latency
  task flips(input int n);
    repeat (n)
    begin
      @(posedge clk);
      flip <= 1'b1;
      @(posedge clk);
      flip <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask : flips

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    xfer(0, 12'h000, 0); chk("ctrl", 32'h0, rv);
    xfer(0, 12'h010, 0); chk("slverr", 32'h1, {31'h0, ev});
    xfer(1, 12'h008, 1); xfer(0, 12'h00c, 0); chk("count", 32'h1, rv);
    xfer(1, 12'h000, 32'h05);
    flips(1); xfer(0, 12'h00c, 0); chk("count", 32'h0, rv);
    flips(1); xfer(0, 12'h00c, 0); chk("count", 32'h0, rv);
    flips(1); xfer(0, 12'h00c, 0); chk("count", 32'hffff, rv);
    chk("irqs", 32'h1, irq_n);
    xfer(1, 12'h000, 32'h04);
    flips(2); xfer(0, 12'h00c, 0); chk("count", 32'hffff, rv);
    xfer(1, 12'h004, 32'h20); xfer(1, 12'h000, 32'h25);
    flips(1); xfer(0, 12'h00c, 0); chk("count", 32'h0, rv);
    xfer(1, 12'h004, 32'h40); xfer(1, 12'h000, 32'ha5);
    flips(2); xfer(0, 12'h00c, 0); chk("count", 32'h2, rv);
    xfer(1, 12'h000, 32'h26); repeat (2) @(posedge clk);
    xfer(0, 12'h000, 0); chk("ctrl", 32'h24, rv);
    xfer(0, 12'h00c, 0); chk("count", 32'h0, rv);
    // one-shot with the up bit set, which must be ignored
    xfer(1, 12'h008, 3); xfer(1, 12'h004, 0); xfer(1, 12'h000, 32'h29);
    repeat (20) @(posedge clk);
    xfer(0, 12'h00c, 0); chk("count", 32'h0, rv);
    xfer(0, 12'h000, 0); chk("ctrl", 32'h28, rv);
    chk("irqs", 32'h3, irq_n);
    chk("ovfs", irq_n, ovf_n);
    // one-shot armed by enable, started and ticked by preceding overflows
    xfer(1, 12'h008, 2); xfer(1, 12'h004, 32'h80); xfer(1, 12'h000, 32'h09);
    repeat (10) @(posedge clk);
    xfer(0, 12'h00c, 0); chk("count", 32'h2, rv);
    flips(3); xfer(0, 12'h00c, 0); chk("count", 32'h1, rv);
    flips(4); xfer(0, 12'h00c, 0); chk("count", 32'h0, rv);
    chk("irqs", 32'h4, irq_n);
    flips(2); xfer(0, 12'h00c, 0); chk("count", 32'h0, rv);
    chk("irqs", 32'h4, irq_n);
    // slow clock ticks so the reset lands while the one-shot runs
    xfer(1, 12'h008, 5); xfer(1, 12'h004, 32'h04); xfer(1, 12'h000, 32'h09);
    xfer(1, 12'h000, 32'h0a); repeat (40) @(posedge clk);
    xfer(0, 12'h00c, 0); chk("count", 32'h5, rv);
    xfer(0, 12'h000, 0); chk("ctrl", 32'h08, rv);
    chk("irqs", 32'h4, irq_n);
    chk("ovfs", irq_n, ovf_n);
    summarize();
  end
endmodule : test_tmr_timer16
